// file: logic/acc_top.sv
// Register file, input routing and system outputs for two comparators.
// Assumes APB master on clk; analog results and timer clock are async.
//
// Operation
// - Minus select routes pins, reference, ground
// - Plus select routes pins, DAC, reference, ground
// - Enable bit seven turns channel on
// - Result bit six reads polarity-adjusted comparison
// - Invert bit four complements the output
// - Hysteresis bit one is read/write control
// - Sync mode updates on timer falling edge
// - Rising edge enable sets event flag
// - Falling edge enable sets event flag
// - Mirror register shows both results
// - Output drives waveform generator shutdown request
// - Selected comparator rising triggers conversion
// - Selected comparator rising resets 8-bit timer
// - Sync path stops in sleep on sysclock
// - Enabled event flag wakes device
// - Two identical channels with own registers
// - Flag software-cleared; concurrent edge wins
// - Toggling invert or enable makes edges
// - Result latched each instruction cycle
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module acc_top #(
    parameter int unsigned INSTR_DIV = acc_pkg::INSTR_DIV_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] cmp_raw,
    input wire logic sync_timer_clk,
    input wire logic sleep_active,
    input wire logic sync_timer_on_sysclk,
    output logic [1:0] analog_enable,
    output logic [1:0] hysteresis_enable,
    output logic [11:0] minus_route,
    output logic [9:0] plus_route,
    output logic [1:0] comparator_out,
    output logic [1:0] edge_event_flag,
    output logic wake_request,
    output logic shutdown_request,
    output logic conversion_trigger,
    output logic timer_reset
);
    localparam int unsigned DIV_W = $clog2(INSTR_DIV + 1);

    // A zero divider would never tick; refuse it at elaboration
    if (INSTR_DIV < 1)
    begin : gen_bad_div
        $error("INSTR_DIV must be at least 1");
    end

    // Register state, per channel and shared
    logic [1:0] en_q;
    logic [1:0] inv_q;
    logic [1:0] hys_q;
    logic [1:0] sync_q;
    logic [1:0] rise_q;
    logic [1:0] fall_q;
    logic [2:0] minus_sel_q [2];
    logic [2:0] plus_sel_q [2];
    logic [1:0] flag_q;
    logic [1:0] ie_q;
    logic [1:0] shdn_en_q;
    acc_pkg::acc_target_t adc_sel_q;
    acc_pkg::acc_target_t tmr_sel_q;
    logic [31:0] rdata_q;

    // Synchronisers
    logic [1:0] raw_meta_q;
    logic [1:0] raw_sync_q;
    logic tclk_meta_q;
    logic tclk_sync_q;
    logic tclk_prev_q;
    logic [DIV_W-1:0] div_q;
    logic [1:0] ext_prev_q;

    logic instr_tick;
    logic tmr_fall;
    logic [1:0] result;
    logic [1:0] ext;
    logic [1:0] edge_evt;
    logic [1:0] ext_rise;
    acc_pkg::acc_cfg_t cfg [2];

    // Bus decode
    logic wr_en;
    logic rd_setup;
    logic [7:0] ofs;
    logic ch_hit;
    logic ch_idx;
    logic [7:0] ch_ofs;
    logic mapped;
    logic [31:0] rd_mux;
    logic [1:0] flag_clr;

    function automatic logic [5:0] minus_decode(input logic [2:0] sel,
        input logic en);
        logic [5:0] r;
        r = 6'h00;
        if (en)
        begin
            if (sel <= 3'h3)
                r[sel[1:0]] = 1'b1;
            else if (sel == acc_pkg::MINUS_FIXED_REF)
                r[4] = 1'b1;
            else if (sel == acc_pkg::MINUS_GROUND)
                r[5] = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [4:0] plus_decode(input logic [2:0] sel,
        input logic en);
        logic [4:0] r;
        r = 5'h00;
        if (en)
        begin
            if (sel <= 3'h1)
                r[sel[0]] = 1'b1;
            else if (sel == acc_pkg::PLUS_DAC)
                r[2] = 1'b1;
            else if (sel == acc_pkg::PLUS_FIXED_REF)
                r[3] = 1'b1;
            else if (sel == acc_pkg::PLUS_GROUND)
                r[4] = 1'b1;
        end
        return r;
    endfunction

    function automatic logic target_hit(input acc_pkg::acc_target_t t,
        input logic [1:0] v);
        logic r;
        case (t)
            acc_pkg::ACC_TGT_FIRST: r = v[0];
            acc_pkg::ACC_TGT_SECOND: r = v[1];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    assign ofs = {paddr[7:2], 2'b00};
    assign ch_hit = ofs < acc_pkg::OFS_MIRROR;
    assign ch_idx = ofs[4];
    assign ch_ofs = {4'h0, ofs[3:0]};
    assign mapped = ch_hit || ofs == acc_pkg::OFS_MIRROR
        || ofs == acc_pkg::OFS_FLAG || ofs == acc_pkg::OFS_IE
        || ofs == acc_pkg::OFS_ROUTE;
    assign wr_en = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = rdata_q;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (ch_hit)
        begin
            case (ch_ofs)
                acc_pkg::OFS_CTRL:
                begin
                    rd_mux[acc_pkg::CTRL_EN] = en_q[ch_idx];
                    rd_mux[acc_pkg::CTRL_OUT] = result[ch_idx];
                    rd_mux[acc_pkg::CTRL_INV] = inv_q[ch_idx];
                    rd_mux[acc_pkg::CTRL_ONE] = 1'b1;
                    rd_mux[acc_pkg::CTRL_HYS] = hys_q[ch_idx];
                    rd_mux[acc_pkg::CTRL_SYNC] = sync_q[ch_idx];
                end
                acc_pkg::OFS_EDGE:
                begin
                    rd_mux[acc_pkg::EDGE_RISE] = rise_q[ch_idx];
                    rd_mux[acc_pkg::EDGE_FALL] = fall_q[ch_idx];
                end
                acc_pkg::OFS_MINUS: rd_mux[2:0] = minus_sel_q[ch_idx];
                acc_pkg::OFS_PLUS: rd_mux[2:0] = plus_sel_q[ch_idx];
                default: rd_mux = 32'h0000_0000;
            endcase
        end
        else
        begin
            case (ofs)
                acc_pkg::OFS_MIRROR: rd_mux[1:0] = result;
                acc_pkg::OFS_FLAG: rd_mux[1:0] = flag_q;
                acc_pkg::OFS_IE: rd_mux[1:0] = ie_q;
                acc_pkg::OFS_ROUTE:
                begin
                    rd_mux[acc_pkg::ROUTE_SHDN +: 2] = shdn_en_q;
                    rd_mux[acc_pkg::ROUTE_ADC +: 2] = adc_sel_q;
                    rd_mux[acc_pkg::ROUTE_TMR +: 2] = tmr_sel_q;
                end
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Instruction-cycle tick and timer falling edge
    assign instr_tick = div_q == DIV_W'(INSTR_DIV - 1);
    // Timer on system clock halts in sleep, freezing the sync path
    assign tmr_fall = tclk_prev_q & ~tclk_sync_q
        & ~(sleep_active & sync_timer_on_sysclk);

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_ch
            assign cfg[g] = '{enable: en_q[g], output_invert: inv_q[g],
                hysteresis_enable: hys_q[g], sync_mode: sync_q[g],
                rise_event_enable: rise_q[g],
                fall_event_enable: fall_q[g]};
            // Both channels are the same logic with own registers
            acc_channel u_ch (
                .clk(clk),
                .rst_n(rst_n),
                .raw_sync(raw_sync_q[g]),
                .instr_tick(instr_tick),
                .tmr_fall(tmr_fall),
                .cfg(cfg[g]),
                .result_bit(result[g]),
                .ext_out(ext[g]),
                .edge_event(edge_evt[g])
            );
            assign minus_route[g*6 +: 6] =
                minus_decode(minus_sel_q[g], en_q[g]);
            assign plus_route[g*5 +: 5] =
                plus_decode(plus_sel_q[g], en_q[g]);
        end
    endgenerate

    assign flag_clr = (wr_en && ofs == acc_pkg::OFS_FLAG) ? pwdata[1:0]
        : 2'b00;
    assign ext_rise = ext & ~ext_prev_q;
    assign analog_enable = en_q;
    assign hysteresis_enable = hys_q;
    assign comparator_out = ext;
    assign edge_event_flag = flag_q;
    assign wake_request = |(flag_q & ie_q);
    // No clock stage, so shutdown is not delayed
    assign shutdown_request = |(ext & shdn_en_q);
    assign conversion_trigger = target_hit(adc_sel_q, ext_rise);
    assign timer_reset = target_hit(tmr_sel_q, ext_rise);

    // Front-end synchronisers and dividers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_meta_q <= 2'b00;
            raw_sync_q <= 2'b00;
            tclk_meta_q <= 1'b0;
            tclk_sync_q <= 1'b0;
            tclk_prev_q <= 1'b0;
            div_q <= '0;
            ext_prev_q <= 2'b00;
        end
        else
        begin
            raw_meta_q <= cmp_raw;
            raw_sync_q <= raw_meta_q;
            tclk_meta_q <= sync_timer_clk;
            tclk_sync_q <= tclk_meta_q;
            tclk_prev_q <= tclk_sync_q;
            div_q <= instr_tick ? '0 : div_q + 1'b1;
            ext_prev_q <= ext;
        end
    end

    // Event flags: a new edge beats a clearing write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_q <= 2'b00;
        else
            flag_q <= (flag_q & ~flag_clr) | edge_evt;
    end

    // Software-written registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_q <= 2'b00;
            inv_q <= 2'b00;
            hys_q <= 2'b00;
            sync_q <= 2'b00;
            rise_q <= 2'b00;
            fall_q <= 2'b00;
            minus_sel_q <= '{acc_pkg::SEL_RESET, acc_pkg::SEL_RESET};
            plus_sel_q <= '{acc_pkg::SEL_RESET, acc_pkg::SEL_RESET};
            ie_q <= 2'b00;
            shdn_en_q <= 2'b00;
            adc_sel_q <= acc_pkg::ACC_TGT_NONE;
            tmr_sel_q <= acc_pkg::ACC_TGT_NONE;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            if (rd_setup)
                rdata_q <= rd_mux;
            if (wr_en && ch_hit && ch_ofs == acc_pkg::OFS_CTRL)
            begin
                en_q[ch_idx] <= pwdata[acc_pkg::CTRL_EN];
                inv_q[ch_idx] <= pwdata[acc_pkg::CTRL_INV];
                hys_q[ch_idx] <= pwdata[acc_pkg::CTRL_HYS];
                sync_q[ch_idx] <= pwdata[acc_pkg::CTRL_SYNC];
            end
            if (wr_en && ch_hit && ch_ofs == acc_pkg::OFS_EDGE)
            begin
                rise_q[ch_idx] <= pwdata[acc_pkg::EDGE_RISE];
                fall_q[ch_idx] <= pwdata[acc_pkg::EDGE_FALL];
            end
            if (wr_en && ch_hit && ch_ofs == acc_pkg::OFS_MINUS)
                minus_sel_q[ch_idx] <= pwdata[2:0];
            if (wr_en && ch_hit && ch_ofs == acc_pkg::OFS_PLUS)
                plus_sel_q[ch_idx] <= pwdata[2:0];
            if (wr_en && ofs == acc_pkg::OFS_IE)
                ie_q <= pwdata[1:0];
            if (wr_en && ofs == acc_pkg::OFS_ROUTE)
            begin
                shdn_en_q <= pwdata[acc_pkg::ROUTE_SHDN +: 2];
                adc_sel_q <= acc_pkg::acc_target_t'(
                    pwdata[acc_pkg::ROUTE_ADC +: 2]);
                tmr_sel_q <= acc_pkg::acc_target_t'(
                    pwdata[acc_pkg::ROUTE_TMR +: 2]);
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/acc_pkg.sv
// Constants and types shared by the analog comparator control logic.
// Assumes an 8-bit APB byte address and 32-bit data words.
`default_nettype none
package acc_pkg;

    localparam int unsigned CH_COUNT = 2;

    // Register byte offsets, channel block stride 0x10
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EDGE = 8'h04;
    localparam logic [7:0] OFS_MINUS = 8'h08;
    localparam logic [7:0] OFS_PLUS = 8'h0C;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] OFS_MIRROR = 8'h20;
    localparam logic [7:0] OFS_FLAG = 8'h24;
    localparam logic [7:0] OFS_IE = 8'h28;
    localparam logic [7:0] OFS_ROUTE = 8'h2C;

    // Control register fields
    localparam int unsigned CTRL_EN = 7;
    localparam int unsigned CTRL_OUT = 6;
    localparam int unsigned CTRL_INV = 4;
    localparam int unsigned CTRL_ONE = 2;
    localparam int unsigned CTRL_HYS = 1;
    localparam int unsigned CTRL_SYNC = 0;
    // Edge enable fields
    localparam int unsigned EDGE_RISE = 1;
    localparam int unsigned EDGE_FALL = 0;
    // Routing register fields
    localparam int unsigned ROUTE_SHDN = 0;
    localparam int unsigned ROUTE_ADC = 2;
    localparam int unsigned ROUTE_TMR = 4;

    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam int unsigned INSTR_DIV_DEF = 4;

    // Minus input one-hot: pins 0..3, fixed reference, ground
    localparam logic [2:0] MINUS_FIXED_REF = 3'h6;
    localparam logic [2:0] MINUS_GROUND = 3'h7;
    // Plus input one-hot: pins 0..1, DAC, fixed reference, ground
    localparam logic [2:0] PLUS_DAC = 3'h5;
    localparam logic [2:0] PLUS_FIXED_REF = 3'h6;
    localparam logic [2:0] PLUS_GROUND = 3'h7;

    // Per-channel software controls
    typedef struct packed {
        logic enable;
        logic output_invert;
        logic hysteresis_enable;
        logic sync_mode;
        logic rise_event_enable;
        logic fall_event_enable;
    } acc_cfg_t;

    // Comparator target select for ADC trigger and timer reset
    typedef enum logic [1:0] {
        ACC_TGT_NONE = 2'b00,
        ACC_TGT_FIRST = 2'b01,
        ACC_TGT_SECOND = 2'b10,
        ACC_TGT_RSVD = 2'b11
    } acc_target_t;

endpackage
`default_nettype wire

// file: logic/acc_channel.sv
// One comparator channel: result latch, sync path and edge detectors.
// Assumes raw_sync is already synchronised to clk.
`timescale 1ns/10ps
`default_nettype none
module acc_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw_sync,
    input wire logic instr_tick,
    input wire logic tmr_fall,
    input wire acc_pkg::acc_cfg_t cfg,
    output logic result_bit,
    output logic ext_out,
    output logic edge_event
);
    logic live;
    logic latch_q;
    logic latch_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic rise;
    logic fall;

    // Disabled channel compares as low, so invert or enable still moves it
    assign live = (cfg.enable & raw_sync) ^ cfg.output_invert;

    assign latch_d = instr_tick ? live : latch_q;
    assign sync_d = tmr_fall ? latch_q : sync_q;

    assign result_bit = cfg.sync_mode ? sync_q : latch_q;
    // Unlatched path for timer and pin when not synchronised
    assign ext_out = cfg.sync_mode ? sync_q : live;

    assign rise = result_bit & ~prev_q;
    assign fall = ~result_bit & prev_q;
    assign edge_event = (rise & cfg.rise_event_enable)
        | (fall & cfg.fall_event_enable);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latch_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            latch_q <= latch_d;
            sync_q <= sync_d;
            prev_q <= result_bit;
        end
    end
endmodule
`default_nettype wire

// file: verif/acc_analog_model.sv
// Analog sources for both comparators: pins, DAC, reference, ground.
// Assumes one-hot routes from acc_top; each level is a logic value.
`timescale 1ns/10ps
`default_nettype none
module acc_analog_model (
    input wire logic [11:0] minus_route,
    input wire logic [9:0] plus_route,
    input wire logic [4:0] plus_lvl,
    input wire logic [5:0] minus_lvl,
    output logic [1:0] cmp_raw
);
    wire logic [4:0] psrc;
    wire logic [5:0] msrc;
    // Ground slot held low whatever the bench drives
    assign psrc = {1'b0, plus_lvl[3:0]};
    assign msrc = {1'b0, minus_lvl[4:0]};
    // Open plus input never wins; open minus input reads low
    assign cmp_raw[0] = |(plus_route[4:0] & psrc)
        & ~|(minus_route[5:0] & msrc);
    assign cmp_raw[1] = |(plus_route[9:5] & psrc)
        & ~|(minus_route[11:6] & msrc);
endmodule
`default_nettype wire

// file: verif/acc_top_sva.sv
// Port checker for acc_top, bound into every instance.
// Assumes one clk domain and async active-low rst_n.
`timescale 1ns/10ps
`default_nettype none
module acc_top_sva #(
    parameter int unsigned INSTR_DIV = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [1:0] analog_enable,
    input wire logic [11:0] minus_route,
    input wire logic [9:0] plus_route,
    input wire logic [1:0] comparator_out,
    input wire logic [1:0] edge_event_flag,
    input wire logic wake_request,
    input wire logic shutdown_request,
    input wire logic conversion_trigger,
    input wire logic timer_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_wake; wake_request |-> |edge_event_flag; endproperty
    a_wake: assert property (p_wake) else $error("wake no flag");
    property p_shdn; shutdown_request |-> |comparator_out; endproperty
    a_shdn: assert property (p_shdn) else $error("shutdown idle");
    property p_conv;
        conversion_trigger |-> (|comparator_out) ##1 !conversion_trigger;
    endproperty
    a_conv: assert property (p_conv) else $error("bad trigger");
    property p_trst;
        timer_reset |-> (|comparator_out) ##1 !timer_reset;
    endproperty
    a_trst: assert property (p_trst) else $error("bad reset");
    property p_off;
        !analog_enable[0] |-> minus_route[5:0] == 6'h00
            && plus_route[4:0] == 5'h00;
    endproperty
    a_off: assert property (p_off) else $error("route when off");
    property p_mone;
        $onehot0(minus_route[5:0]) && $onehot0(minus_route[11:6]);
    endproperty
    a_mone: assert property (p_mone) else $error("minus route");
    property p_pone;
        $onehot0(plus_route[4:0]) && $onehot0(plus_route[9:5]);
    endproperty
    a_pone: assert property (p_pone) else $error("plus route");
    property p_clr;
        $fell(edge_event_flag[0]) |-> $past(psel && penable && pwrite
            && paddr == acc_pkg::OFS_FLAG && pwdata[0]);
    endproperty
    a_clr: assert property (p_clr) else $error("flag lost");
endmodule
bind acc_top acc_top_sva #(.INSTR_DIV(INSTR_DIV)) u_sva (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .analog_enable(analog_enable),
    .minus_route(minus_route),
    .plus_route(plus_route),
    .comparator_out(comparator_out),
    .edge_event_flag(edge_event_flag),
    .wake_request(wake_request),
    .shutdown_request(shutdown_request),
    .conversion_trigger(conversion_trigger),
    .timer_reset(timer_reset)
);
`default_nettype wire

// file: verif/acc_top_bench.sv
// Self-checking bench for acc_top with the analog source model.
// Assumes an APB slave answering via pready; register shadow in mreg.
`timescale 1ns/10ps
`default_nettype none
module acc_top_bench;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, run;
    logic sync_timer_clk, sleep_active, sync_timer_on_sysclk;
    logic wake_request, shutdown_request, conversion_trigger, timer_reset;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] cmp_raw, analog_enable, hysteresis_enable;
    logic [1:0] comparator_out, edge_event_flag;
    logic [11:0] minus_route;
    logic [9:0] plus_route;
    logic [4:0] plus_lvl;
    logic [5:0] minus_lvl;
    int errors, n_tests, nconv, ntrst, tdiv, c0, t0, g;
    int unsigned mreg [64];
    acc_top #(.INSTR_DIV(4)) dut (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cmp_raw(cmp_raw),
        .sync_timer_clk(sync_timer_clk),
        .sleep_active(sleep_active),
        .sync_timer_on_sysclk(sync_timer_on_sysclk),
        .analog_enable(analog_enable),
        .hysteresis_enable(hysteresis_enable),
        .minus_route(minus_route),
        .plus_route(plus_route),
        .comparator_out(comparator_out),
        .edge_event_flag(edge_event_flag),
        .wake_request(wake_request),
        .shutdown_request(shutdown_request),
        .conversion_trigger(conversion_trigger),
        .timer_reset(timer_reset)
    );
    acc_analog_model partner (
        .minus_route(minus_route),
        .plus_route(plus_route),
        .plus_lvl(plus_lvl),
        .minus_lvl(minus_lvl),
        .cmp_raw(cmp_raw)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        tdiv <= tdiv + 1;
        if (run && tdiv % 3 == 0)
            sync_timer_clk <= ~sync_timer_clk;
        if (conversion_trigger === 1'b1)
            nconv <= nconv + 1;
        if (timer_reset === 1'b1)
            ntrst <= ntrst + 1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        #1;
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let this edge's register updates land before callers compare
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
        mreg[a] = v;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic lvl(input logic v);
        @(posedge clk);
        plus_lvl <= {4'h0, v};
        repeat (30) @(posedge clk);
        #1;
    endtask
    function automatic logic mres(input int ch);
        int unsigned c;
        logic raw;
        c = mreg[16 * ch];
        raw = plus_lvl[0] && mreg[16 * ch + 12] % 8 == 0
            && mreg[16 * ch + 8] % 8 == 7;
        return (c[7] & raw) ^ c[4];
    endfunction
    function automatic logic [5:0] mexp(input int c);
        return c < 4 ? 6'h01 << c : c == 6 ? 6'h10 : c == 7 ? 6'h20 : 6'h00;
    endfunction
    function automatic logic [4:0] pexp(input int c);
        return c < 2 ? 5'h01 << c : c > 4 ? 5'h01 << (c - 3) : 5'h00;
    endfunction
    task automatic close_out;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {plus_lvl, minus_lvl, sync_timer_clk, sleep_active} = '0;
        {sync_timer_on_sysclk, nconv, ntrst, tdiv} = '0;
        run = 1'b1;
        void'($urandom(72863));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rc(8'h00, 32'h04);
        rc(8'h10, 32'h04);
        rc(8'h20, 32'h00);
        rc(8'h30, 32'h00);
        chk(err, 1'b1);
        // Sweep every select code on both channels, random control bits
        for (int i = 0; i < 16; i++)
        begin
            g = i % 2;
            b = g ? 8'h10 : 8'h00;
            wr(b, $urandom);
            wr(b + 8'h04, $urandom);
            wr(b + 8'h08, ($urandom & ~32'h7) | 32'(i / 2));
            wr(b + 8'h0C, ($urandom & ~32'h7) | 32'(7 - i / 2));
            repeat (40) @(posedge clk);
            rc(b, mreg[b] & 32'h93 | 32'h04 | {mres(g), 6'h00});
            rc(b + 8'h04, mreg[b + 4] & 32'h3);
            rc(b + 8'h08, mreg[b + 8] & 32'h7);
            rc(b + 8'h0C, mreg[b + 12] & 32'h7);
            chk(minus_route[6 * g +: 6], mreg[b][7] ? mexp(i / 2) : 0);
            chk(plus_route[5 * g +: 5], mreg[b][7] ? pexp(7 - i / 2) : 0);
            chk(analog_enable[g], mreg[b][7]);
            chk(hysteresis_enable[g], mreg[b][1]);
            rc(8'h20, {mres(1), mres(0)});
        end
        wr(8'h10, 32'h0);
        wr(8'h0C, 32'h0);
        wr(8'h08, 32'h7);
        wr(8'h04, 32'h2);
        wr(8'h28, 32'h1);
        wr(8'h00, 32'h80);
        repeat (40) @(posedge clk);
        wr(8'h24, 32'h3);
        chk(edge_event_flag, 2'b00);
        lvl(1'b1);
        chk(edge_event_flag, 2'b01);
        chk(wake_request, 1'b1);
        rc(8'h00, 32'hC4);
        wr(8'h24, 32'h1);
        chk(edge_event_flag, 2'b00);
        chk(wake_request, 1'b0);
        lvl(1'b0);
        chk(edge_event_flag, 2'b00);
        wr(8'h04, 32'h1);
        lvl(1'b1);
        chk(edge_event_flag, 2'b00);
        lvl(1'b0);
        chk(edge_event_flag, 2'b01);
        wr(8'h24, 32'h1);
        wr(8'h00, 32'h90);
        repeat (30) @(posedge clk);
        rc(8'h00, 32'hD4);
        wr(8'h00, 32'h10);
        wr(8'h00, 32'h00);
        repeat (30) @(posedge clk);
        chk(edge_event_flag, 2'b01);
        wr(8'h2C, 32'h15);
        wr(8'h00, 32'h80);
        c0 = nconv;
        t0 = ntrst;
        lvl(1'b1);
        chk(nconv - c0, 1);
        chk(ntrst - t0, 1);
        chk(shutdown_request, 1'b1);
        lvl(1'b0);
        chk(shutdown_request, 1'b0);
        // Targets name the idle second channel: first must not trigger
        wr(8'h2C, 32'h2A);
        lvl(1'b1);
        chk(nconv - c0, 1);
        chk(ntrst - t0, 1);
        chk(shutdown_request, 1'b0);
        wr(8'h00, 32'h81);
        run = 1'b0;
        lvl(1'b0);
        chk(comparator_out[0], 1'b1);
        run = 1'b1;
        repeat (40) @(posedge clk);
        chk(comparator_out[0], 1'b0);
        @(posedge clk);
        sleep_active <= 1'b1;
        sync_timer_on_sysclk <= 1'b1;
        lvl(1'b1);
        chk(comparator_out[0], 1'b0);
        @(posedge clk);
        sleep_active <= 1'b0;
        repeat (40) @(posedge clk);
        chk(comparator_out[0], 1'b1);
        rc(8'h00, 32'hC5);
        close_out();
    end
endmodule
`default_nettype wire
